// file: core/lddiag_top.v
`timescale 1ns/100ps
`include "lddiag_defines.vh"
module lddiag_top #(
  parameter [`CNT_W-1:0] ENLOW_CYC = `ENLOW_MS * `CLK_KHZ,
  parameter [`CNT_W-1:0] PULSE_CYC = `PULSE_MS * `CLK_KHZ
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // APB slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Channel pins
  input wire [1:0] chanEnableIn,
  output reg [1:0] chanFaultOut,
  // Serial frame pins, watched for length only
  input wire serCsN,
  input wire serClk,
  // Analog comparator and temperature levels, asynchronous
  input wire boostUvDet,
  input wire boostDutyMaxDet,
  input wire tempShutdownLive,
  input wire tempWarnLive,
  input wire [1:0] ocCmp,
  // Same-clock converter inputs
  input wire [1:0] buckPeriodTick,
  input wire [7:0] stringVoltage0,
  input wire [7:0] stringVoltage1,
  // Nonvolatile defaults, stable straps
  input wire nvmDiagMode,
  input wire [3:0] nvmBoostRange,
  input wire [7:0] nvmLimit0,
  input wire [7:0] nvmLimit1,
  input wire [7:0] nvmDuty0,
  input wire [7:0] nvmDuty1,
  // Converter controls
  output reg [1:0] chanDriveEn,
  output reg boostEn,
  output reg [7:0] dimDutyOut0,
  output reg [7:0] dimDutyOut1
);

  // Open threshold as an ADC code, scale 80 V over 255 codes
  function [7:0] openCode;
    input [3:0] range;
    reg [31:0] volts;
    begin
      volts = 32'h00000000;
      case (range)
        4'h0: volts = `OPEN_V0;
        4'h1: volts = `OPEN_V1;
        4'h2: volts = `OPEN_V2;
        4'h3: volts = `OPEN_V3;
        4'h4: volts = `OPEN_V4;
        4'h5: volts = `OPEN_V5;
        4'h6: volts = `OPEN_V6;
        4'h7: volts = `OPEN_V7;
        4'h8: volts = `OPEN_V8;
        4'h9: volts = `OPEN_V9;
        4'ha: volts = `OPEN_V10;
        4'hb: volts = `OPEN_V11;
        4'hc: volts = `OPEN_V12;
        4'hd: volts = `OPEN_V13;
        4'he: volts = `OPEN_V14;
        default: volts = `OPEN_V15;
      endcase
      openCode = sat8((volts * `FS_CODE) / `FS_VOLT);
    end
  endfunction

  // Clamp to one byte
  function [7:0] sat8;
    input [31:0] val;
    begin
      sat8 = (val > 32'h000000ff) ? 8'hff : val[7:0];
    end
  endfunction

  // Scaled dimming duty under derating
  function [7:0] derate;
    input [7:0] duty;
    reg [9:0] prod;
    begin
      prod = {2'b00, duty} * `DERATE_MUL;
      derate = prod[9:`DERATE_SHIFT];
    end
  endfunction

  localparam SY_W = 10;
  localparam SY_TSD = 2;
  localparam SY_TW = 3;
  localparam SY_CS = 4;
  localparam SY_SCK = 5;
  localparam SY_UV = 6;
  localparam SY_DMAX = 7;

  // Two-flop synchroniser for every asynchronous level
  reg [SY_W-1:0] syncA_r;
  reg [SY_W-1:0] syncB_r;
  wire [SY_W-1:0] asyncIn = {ocCmp, boostDutyMaxDet, boostUvDet, serClk, serCsN,
    tempWarnLive, tempShutdownLive, chanEnableIn};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= {SY_W{1'b0}};
      syncB_r <= {SY_W{1'b0}};
    end else begin
      syncA_r <= asyncIn;
      syncB_r <= syncA_r;
    end
  end

  wire [1:0] enS = syncB_r[1:0];
  wire tsdS = syncB_r[SY_TSD];
  wire twS = syncB_r[SY_TW];
  wire csS = syncB_r[SY_CS];
  wire sckS = syncB_r[SY_SCK];
  wire uvS = syncB_r[SY_UV];
  wire dmaxS = syncB_r[SY_DMAX];
  wire [1:0] ocS = syncB_r[9:8];

  // APB decode; no wait states
  assign pready = 1'b1;
  wire setupPh = psel & ~penable;
  wire accPh = psel & penable;
  wire rdDone = accPh & ~pwrite;
  wire wrDone = accPh & pwrite;
  reg mapped;
  always @* begin
    case (paddr)
      `ADDR_SSA, `ADDR_SSB, `ADDR_CS0, `ADDR_CS1, `ADDR_CFG, `ADDR_LIM0,
      `ADDR_LIM1, `ADDR_DUTY0, `ADDR_DUTY1, `ADDR_LIVE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = accPh & ~mapped;

  // Startup load of nonvolatile defaults, then APB writes
  reg loaded_r;
  reg diagMode_r;
  reg [3:0] range_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_r <= 1'b0;
      diagMode_r <= 1'b0;
      range_r <= `RST_RANGE;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      diagMode_r <= nvmDiagMode;
      range_r <= nvmBoostRange;
    end else if (wrDone && paddr == `ADDR_CFG) begin
      range_r <= pwdata[3:0];
    end
  end

  // Serial frame length watch, bits counted modulo 16
  reg sckD_r;
  reg csD_r;
  reg [3:0] bitCnt_r;
  wire frameErrEv = csS & ~csD_r & (bitCnt_r != 4'h0);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sckD_r <= 1'b0;
      csD_r <= 1'b1;
      bitCnt_r <= 4'h0;
    end else begin
      sckD_r <= sckS;
      csD_r <= csS;
      if (!csS && csD_r) begin
        bitCnt_r <= 4'h0;
      end else if (!csS && sckS && !sckD_r) begin
        bitCnt_r <= bitCnt_r + 4'h1;
      end
    end
  end

  // Thermal hold: released only when shutdown and warning are both gone
  reg thermHold_r;
  wire thermAny = tsdS | thermHold_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thermHold_r <= 1'b0;
    end else if (tsdS) begin
      thermHold_r <= 1'b1;
    end else if (!twS) begin
      thermHold_r <= 1'b0;
    end
  end

  // Read snapshot, taken in setup, used as the clear mask at access
  reg [7:0] rdMux;
  reg [7:0] snap_r;
  wire [7:0] chStat0;
  wire [7:0] chStat1;
  wire [15:0] limAll;
  wire [15:0] dutyAll;
  reg [2:0] ssa_r;
  reg [1:0] ssb_r;
  always @* begin
    case (paddr)
      `ADDR_SSA: rdMux = {1'b0, ssa_r, 4'h0};
      `ADDR_SSB: rdMux = {1'b0, twS, ssb_r, 4'h0};
      `ADDR_CS0: rdMux = chStat0;
      `ADDR_CS1: rdMux = chStat1;
      `ADDR_CFG: rdMux = {diagMode_r, 3'b000, range_r};
      `ADDR_LIM0: rdMux = limAll[7:0];
      `ADDR_LIM1: rdMux = limAll[15:8];
      `ADDR_DUTY0: rdMux = dutyAll[7:0];
      `ADDR_DUTY1: rdMux = dutyAll[15:8];
      `ADDR_LIVE: rdMux = {boostEn, thermAny, chanDriveEn, 2'b00, chanFaultOut};
      default: rdMux = `RST_BYTE;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_r <= `RST_BYTE;
      prdata <= 32'h00000000;
    end else if (setupPh) begin
      snap_r <= rdMux;
      prdata <= {24'h000000, rdMux};
    end
  end
  wire rdSsa = rdDone && paddr == `ADDR_SSA;
  wire rdSsb = rdDone && paddr == `ADDR_SSB;
  wire [1:0] rdCs = {rdDone && paddr == `ADDR_CS1, rdDone && paddr == `ADDR_CS0};

  // Shared status flags; set wins over clear
  wire [1:0] enLowClr;
  wire [2:0] ssaSet = {uvS, dmaxS, twS};
  wire [2:0] ssaClr = (rdSsa ? snap_r[6:4] : 3'b000)
    | {enLowClr[0] | enLowClr[1], 2'b00};
  wire [1:0] ssbSet = {tsdS, frameErrEv};
  wire [1:0] ssbClr = rdSsb ? snap_r[5:4] : 2'b00;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ssa_r <= 3'b000;
      ssb_r <= 2'b00;
    end else begin
      ssa_r <= (ssa_r & ~ssaClr) | ssaSet;
      ssb_r <= (ssb_r & ~ssbClr) | ssbSet;
    end
  end

  // Boost runs unless a thermal hold is active
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boostEn <= 1'b0;
    end else begin
      boostEn <= loaded_r & ~thermAny;
    end
  end

  wire [1:0] faultNxt;
  wire [1:0] driveNxt;
  wire [7:0] openThr = openCode(range_r);

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gCh
      wire [7:0] vCode = (g == 0) ? stringVoltage0 : stringVoltage1;
      wire [7:0] limAddr = (g == 0) ? `ADDR_LIM0 : `ADDR_LIM1;
      wire [7:0] dutyAddr = (g == 0) ? `ADDR_DUTY0 : `ADDR_DUTY1;
      wire [7:0] nvmLim = (g == 0) ? nvmLimit0 : nvmLimit1;
      wire [7:0] nvmDut = (g == 0) ? nvmDuty0 : nvmDuty1;
      reg [7:0] lim_r;
      reg [7:0] duty_r;
      reg [3:0] stat_r;
      reg [3:0] ocCnt_r;
      reg ocOff_r;
      reg pinHold_r;
      reg driveD_r;
      reg [`CNT_W-1:0] pulseCnt_r;
      wire drive = chanDriveEn[g];

      // Enable-low timer for this channel
      lddiag_hold_timer #(
        .CYCLES(ENLOW_CYC)
      ) uTimer (
        .clk(clk),
        .rst_n(rst_n),
        .levelHigh(enS[g]),
        .expired(enLowClr[g])
      );

      // Limit and duty: nonvolatile default, then volatile overwrite
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          lim_r <= `RST_BYTE;
          duty_r <= `RST_BYTE;
        end else if (!loaded_r) begin
          lim_r <= nvmLim;
          duty_r <= nvmDut;
        end else if (wrDone) begin
          if (paddr == limAddr) begin
            lim_r <= pwdata[7:0];
          end
          if (paddr == dutyAddr) begin
            duty_r <= pwdata[7:0];
          end
        end
      end

      // String detections while the channel drives
      wire openEv = drive & (vCode >= openThr);
      wire shortEv = drive & (vCode < `SHORT_CODE);
      wire singleEv = drive & (vCode < lim_r);
      wire ocEv = buckPeriodTick[g] & ocS[g] & (ocCnt_r == `OC_LAST);

      // Consecutive overcurrent periods
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ocCnt_r <= 4'h0;
        end else if (buckPeriodTick[g]) begin
          if (!ocS[g] || !drive) begin
            ocCnt_r <= 4'h0;
          end else if (ocCnt_r != `OC_LAST) begin
            ocCnt_r <= ocCnt_r + 4'h1;
          end
        end
      end

      // Status flags; read or enable-low clears, set wins
      wire [3:0] sSet = {openEv, shortEv, singleEv, ocEv};
      wire [3:0] sClr = (rdCs[g] ? snap_r[3:0] : 4'h0) | {4{enLowClr[g]}};
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stat_r <= 4'h0;
        end else begin
          stat_r <= (stat_r & ~sClr) | sSet;
        end
      end

      // Pin hold survives a status read, released only by enable-low
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pinHold_r <= 1'b0;
          ocOff_r <= 1'b0;
        end else begin
          if (openEv | shortEv | ocEv | uvS) begin
            pinHold_r <= 1'b1;
          end else if (enLowClr[g]) begin
            pinHold_r <= 1'b0;
          end
          if (ocEv) begin
            ocOff_r <= 1'b1;
          end else if (enLowClr[g]) begin
            ocOff_r <= 1'b0;
          end
        end
      end

      // One-shot pulse window from turn-on
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          driveD_r <= 1'b0;
          pulseCnt_r <= {`CNT_W{1'b0}};
        end else begin
          driveD_r <= drive;
          if (drive && !driveD_r) begin
            pulseCnt_r <= PULSE_CYC;
          end else if (!drive) begin
            pulseCnt_r <= {`CNT_W{1'b0}};
          end else if (pulseCnt_r != {`CNT_W{1'b0}}) begin
            pulseCnt_r <= pulseCnt_r - 1'b1;
          end
        end
      end

      wire pulseOn = pulseCnt_r != {`CNT_W{1'b0}};
      wire errPin = pinHold_r | thermAny | openEv | shortEv | uvS;
      assign faultNxt[g] = drive & ~errPin & (diagMode_r ? pulseOn : 1'b1);
      assign driveNxt[g] = loaded_r & enS[g] & ~ocOff_r & ~thermAny;
      assign limAll[8*g+7:8*g] = lim_r;
      assign dutyAll[8*g+7:8*g] = duty_r;
    end
  endgenerate

  assign chStat0 = {4'h0, gCh[0].stat_r};
  assign chStat1 = {4'h0, gCh[1].stat_r};

  // Registered pins and converter controls
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chanFaultOut <= 2'b00;
      chanDriveEn <= 2'b00;
      dimDutyOut0 <= `RST_BYTE;
      dimDutyOut1 <= `RST_BYTE;
    end else begin
      chanFaultOut <= faultNxt;
      chanDriveEn <= driveNxt;
      dimDutyOut0 <= twS ? derate(dutyAll[7:0]) : dutyAll[7:0];
      dimDutyOut1 <= twS ? derate(dutyAll[15:8]) : dutyAll[15:8];
    end
  end

endmodule // lddiag_top

// file: core/lddiag_defines.vh
// Contract
// - Converters restart after live shutdown and warning clear
// - Flag serial frames not whole 16-bit words
// - Boost undervoltage sets flag, drops both outputs
// - Undervoltage clears by read or long enable-low
// - Open string flagged at range-coded voltage threshold
// - Open keeps output low until cleared
// - String short below code 06 hex
// - Short holds output low until enable-low period
// - Single-LED short below programmable 80V/255 limit
// - Single-short limit loads nonvolatile default, writable
// - Single-LED short touches status only
// - Sixteen overcurrent periods flag, disable, drop output
// - Overcurrent clears by read or enable-low
// - Nonvolatile mode bit selects static or pulsed
// - Static mode: output high while channel healthy
// - Pulsed mode: one 500 ms pulse at turn-on
// - Output low while any reporting error persists
// - Shared status A bit layout, read clears
// - Shared status B layout, enable never clears
// - Channel status bit layout, read or enable clears
// - Shutdown disables outputs, recovery below warning
// - Shutdown flag latched until status B read
// - Warning derates dimming duty to 75 percent
`ifndef LDDIAG_DEFINES_VH
`define LDDIAG_DEFINES_VH

// Register byte addresses
`define ADDR_SSA 8'h00
`define ADDR_SSB 8'h04
`define ADDR_CS0 8'h08
`define ADDR_CS1 8'h0c
`define ADDR_CFG 8'h10
`define ADDR_LIM0 8'h14
`define ADDR_LIM1 8'h18
`define ADDR_DUTY0 8'h1c
`define ADDR_DUTY1 8'h20
`define ADDR_LIVE 8'h24

// Field positions
`define SSA_UV 6
`define SSA_DUTY 5
`define SSA_DERATE 4
`define SSB_WARN 6
`define SSB_TSD 5
`define SSB_FRAME 4
`define CS_OPEN 3
`define CS_SHORT 2
`define CS_SINGLE 1
`define CS_OC 0
`define CFG_MODE 7

// Reset values
`define RST_BYTE 8'h00
`define RST_RANGE 4'h0

// Detection constants
`define SHORT_CODE 8'h06
`define OC_LAST 4'hf
`define FS_VOLT 80
`define FS_CODE 255
`define DERATE_MUL 10'd3
`define DERATE_SHIFT 2

// Open-string thresholds in volts per boost range code
`define OPEN_V0 13
`define OPEN_V1 13
`define OPEN_V2 13
`define OPEN_V3 15
`define OPEN_V4 18
`define OPEN_V5 20
`define OPEN_V6 23
`define OPEN_V7 25
`define OPEN_V8 28
`define OPEN_V9 30
`define OPEN_V10 33
`define OPEN_V11 35
`define OPEN_V12 38
`define OPEN_V13 40
`define OPEN_V14 45
`define OPEN_V15 55

// Timing
`define CLK_KHZ 24'd20000
`define ENLOW_MS 24'd50
`define PULSE_MS 24'd500
`define CNT_W 24

`endif

// file: core/lddiag_hold_timer.v
`timescale 1ns/100ps
`include "lddiag_defines.vh"
module lddiag_hold_timer #(
  parameter [`CNT_W-1:0] CYCLES = `ENLOW_MS * `CLK_KHZ
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Synchronised enable level
  input wire levelHigh,
  // One-cycle pulse when the level has been low for CYCLES
  output reg expired
);

  reg [`CNT_W-1:0] cnt_r;
  reg done_r;

  // Counts low time, restarts on any high level, fires once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {`CNT_W{1'b0}};
      done_r <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (levelHigh) begin
        cnt_r <= {`CNT_W{1'b0}};
        done_r <= 1'b0;
      end else if (!done_r) begin
        if (cnt_r == CYCLES - 1'b1) begin
          done_r <= 1'b1;
          expired <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule // lddiag_hold_timer

// file: testbench/lddiag_chk.sv
`timescale 1ns/100ps
`include "lddiag_defines.vh"
module lddiag_chk #(
  parameter [`CNT_W-1:0] PULSE_CYC = 24'd40
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // APB
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pslverr,
  // Pins and levels
  input wire [1:0] chanFaultOut,
  input wire [1:0] chanDriveEn,
  input wire boostEn,
  input wire boostUvDet,
  input wire tempShutdownLive,
  input wire tempWarnLive,
  input wire [7:0] stringVoltage0,
  input wire nvmDiagMode
);
  reg [`CNT_W-1:0] hiCnt_r;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Length of the current high run on the channel 0 output
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) hiCnt_r <= '0;
    else hiCnt_r <= chanFaultOut[0] ? hiCnt_r + 1'b1 : '0;
  end
  chk_uv_pins: assert property (boostUvDet [*4] |=> chanFaultOut == 2'b00)
    else $error("fault output high during undervoltage");
  chk_tsd_off: assert property (tempShutdownLive [*4] |=>
    {boostEn, chanDriveEn, chanFaultOut} == 5'h00) else $error("outputs on in shutdown");
  chk_boost_restart: assert property ($rose(boostEn) |->
    !$past(tempShutdownLive, 3) && !$past(tempWarnLive, 3)) else $error("early restart");
  chk_short_pin: assert property (
    (chanDriveEn[0] && stringVoltage0 < `SHORT_CODE) [*4] |=> !chanFaultOut[0])
    else $error("fault output high with shorted string");
  chk_active_only: assert property (chanFaultOut[0] |-> $past(chanDriveEn[0]))
    else $error("fault output high with channel off");
  chk_pulse_len: assert property (nvmDiagMode |-> hiCnt_r <= PULSE_CYC)
    else $error("pulse too long");
  chk_bad_addr: assert property (psel && penable && paddr > `ADDR_LIVE |-> pslverr)
    else $error("unmapped access not refused");
  chk_read_width: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  cov_pulse: cover property (nvmDiagMode && $rose(chanFaultOut[0]));
  cov_refused: cover property (psel && penable && pslverr);
  cov_restart: cover property ($rose(boostEn) && chanDriveEn == 2'b00);
endmodule // lddiag_chk

bind lddiag_top lddiag_chk #(.PULSE_CYC(PULSE_CYC)) chk (
  .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr), .chanFaultOut(chanFaultOut),
  .chanDriveEn(chanDriveEn), .boostEn(boostEn), .boostUvDet(boostUvDet),
  .tempShutdownLive(tempShutdownLive), .tempWarnLive(tempWarnLive),
  .stringVoltage0(stringVoltage0), .nvmDiagMode(nvmDiagMode));

// file: testbench/lddiag_frame_master.sv
`timescale 1ns/100ps
module lddiag_frame_master (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Frame request
  input wire frameGo,
  input wire [5:0] frameBits,
  // Serial pins and status
  output reg serCsN,
  output reg serClk,
  output reg frameBusy
);
  reg [7:0] phase_r;
  // Frame of frameBits clocks; clock stands low outside frames
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serCsN <= 1'b1;
      serClk <= 1'b0;
      frameBusy <= 1'b0;
      phase_r <= 8'h00;
    end else if (frameGo && !frameBusy) begin
      serCsN <= 1'b0;
      frameBusy <= 1'b1;
      phase_r <= 8'h00;
    end else if (frameBusy) begin
      phase_r <= phase_r + 8'h01;
      serClk <= (phase_r < {frameBits, 2'b00}) ? phase_r[1] : 1'b0;
      if (phase_r == {frameBits, 2'b00} + 8'h04) begin
        serCsN <= 1'b1;
        frameBusy <= 1'b0;
      end
    end
  end
endmodule // lddiag_frame_master

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`include "lddiag_defines.vh"
module tb_top;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, boostEn;
  logic serCsN, serClk, frameGo, frameBusy, nvmDiagMode;
  logic boostUvDet, boostDutyMaxDet, tempShutdownLive, tempWarnLive;
  logic [1:0] chanEnableIn, chanFaultOut, ocCmp, buckPeriodTick, chanDriveEn;
  logic [3:0] nvmBoostRange;
  logic [5:0] frameBits;
  logic [7:0] paddr, stringVoltage0, stringVoltage1, nvmLimit0, nvmLimit1;
  logic [7:0] nvmDuty0, nvmDuty1, dimDutyOut0, dimDutyOut1;
  logic [31:0] pwdata, prdata, rnd;
  logic [32:0] expq[$];
  int failures, checks, seed, i, n, thr;
  int volts[16] = '{13, 13, 13, 15, 18, 20, 23, 25, 28, 30, 33, 35, 38, 40, 45, 55};

  lddiag_top #(.ENLOW_CYC(24'd20), .PULSE_CYC(24'd40)) uut (.*);
  lddiag_frame_master partner (.*);

  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Compare and count
  task ck(input [32:0] g, input [32:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Counts, verdict, stop
  task end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cy(input int c);
    repeat (c) @(posedge clk);
  endtask
  task tmo(input int k);
    if (k >= 400) begin
      failures++;
      end_of_test;
    end
  endtask
  // APB transfer; a read notes its expected {pslverr, prdata}
  task apb(input [7:0] a, input w, input [31:0] d, input [32:0] e);
    if (!w) expq.push_back(e);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; pready !== 1'b1 && n < 400; n++) @(posedge clk);
    tmo(n);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Buck period pulses on channel 0
  task tick(input int c);
    repeat (c) begin
      buckPeriodTick <= 2'b01;
      @(posedge clk);
      buckPeriodTick <= 2'b00;
      @(posedge clk);
    end
  endtask
  // Enable low past the clear period, then on again
  task enl(input [1:0] m);
    chanEnableIn <= chanEnableIn & ~m;
    cy(30);
    chanEnableIn <= chanEnableIn | m;
    cy(10);
  endtask
  // One serial frame through the partner
  task frame(input [5:0] b);
    frameBits <= b;
    frameGo <= 1'b1;
    cy(2);
    frameGo <= 1'b0;
    for (n = 0; frameBusy === 1'b1 && n < 400; n++) @(posedge clk);
    tmo(n);
    cy(6);
  endtask
  // Take the oldest note at each completed read
  always @(posedge clk)
    if (psel && penable && pready && !pwrite) ck({pslverr, prdata}, expq.pop_front());

  // Main sequence
  initial begin
    seed = 42758;
    rst_n = 1'b0;
    {psel, penable, pwrite, frameGo, nvmDiagMode, ocCmp, buckPeriodTick} = '0;
    {boostUvDet, boostDutyMaxDet, tempShutdownLive, tempWarnLive} = '0;
    {paddr, pwdata, nvmBoostRange, frameBits, chanEnableIn} = '0;
    {stringVoltage0, stringVoltage1, nvmLimit0, nvmLimit1} = 32'h14140808;
    nvmDuty0 = 8'($random(seed));
    nvmDuty1 = 8'($random(seed));
    cy(16);
    rst_n <= 1'b1;
    cy(2);
    apb(`ADDR_SSB, 0, 0, 33'h0);
    apb(`ADDR_CFG, 0, 0, 33'h0);
    apb(`ADDR_LIM0, 0, 0, 33'h08);
    apb(8'h28, 0, 0, 33'h100000000);
    chanEnableIn <= 2'b11;
    cy(10);
    ck(chanFaultOut, 2'b11);
    ck(dimDutyOut0, nvmDuty0);
    ck(dimDutyOut1, nvmDuty1);
    // Single-LED limit boundary, short boundary
    apb(`ADDR_LIM0, 1, 32'h10, 0);
    stringVoltage0 <= 8'h10;
    cy(5);
    apb(`ADDR_CS0, 0, 0, 33'h00);
    stringVoltage0 <= 8'h06;
    cy(5);
    ck(chanFaultOut, 2'b11);
    stringVoltage0 <= 8'h14;
    cy(3);
    apb(`ADDR_CS0, 0, 0, 33'h02);
    apb(`ADDR_CS0, 0, 0, 33'h00);
    stringVoltage0 <= 8'h05;
    cy(5);
    ck(chanFaultOut, 2'b10);
    stringVoltage0 <= 8'h14;
    cy(3);
    apb(`ADDR_CS0, 0, 0, 33'h06);
    ck(chanFaultOut, 2'b10);
    enl(2'b01);
    ck(chanFaultOut, 2'b11);
    // Open threshold for every range code
    for (i = 0; i < 16; i++) begin
      apb(`ADDR_CFG, 1, i, 0);
      thr = volts[i] * 255 / 80;
      stringVoltage1 <= 8'(thr - 1);
      cy(4);
      stringVoltage1 <= 8'(thr);
      cy(4);
      stringVoltage1 <= 8'(thr - 1);
      cy(3);
      apb(`ADDR_CS1, 0, 0, 33'h08);
      apb(`ADDR_CS1, 0, 0, 33'h00);
    end
    ck(chanFaultOut, 2'b01);
    stringVoltage1 <= 8'h14;
    enl(2'b10);
    ck(chanFaultOut, 2'b11);
    // Overcurrent count of 16 periods
    ocCmp <= 2'b01;
    cy(4);
    tick(15);
    cy(4);
    ck(chanDriveEn, 2'b11);
    tick(1);
    cy(4);
    ck({chanDriveEn, chanFaultOut}, 4'b1010);
    ocCmp <= 2'b00;
    apb(`ADDR_CS0, 0, 0, 33'h01);
    apb(`ADDR_CS0, 0, 0, 33'h00);
    enl(2'b01);
    ck({chanDriveEn, chanFaultOut}, 4'b1111);
    // Undervoltage, cleared by enable-low
    boostUvDet <= 1'b1;
    cy(6);
    ck(chanFaultOut, 2'b00);
    boostUvDet <= 1'b0;
    cy(4);
    apb(`ADDR_SSA, 0, 0, 33'h40);
    apb(`ADDR_SSA, 0, 0, 33'h00);
    ck(chanFaultOut, 2'b00);
    enl(2'b11);
    apb(`ADDR_SSA, 0, 0, 33'h00);
    ck(chanFaultOut, 2'b11);
    // Duty limit and warning derating
    rnd = $random(seed);
    apb(`ADDR_DUTY0, 1, rnd, 0);
    boostDutyMaxDet <= 1'b1;
    tempWarnLive <= 1'b1;
    cy(6);
    boostDutyMaxDet <= 1'b0;
    cy(4);
    ck(dimDutyOut0, (rnd[7:0] * 10'd3) >> 2);
    ck(dimDutyOut1, (nvmDuty1 * 10'd3) >> 2);
    apb(`ADDR_SSA, 0, 0, 33'h30);
    apb(`ADDR_SSB, 0, 0, 33'h40);
    apb(`ADDR_SSB, 0, 0, 33'h40);
    tempWarnLive <= 1'b0;
    cy(5);
    apb(`ADDR_SSA, 0, 0, 33'h10);
    apb(`ADDR_SSA, 0, 0, 33'h00);
    ck(dimDutyOut0, rnd[7:0]);
    ck(dimDutyOut1, nvmDuty1);
    // Frame lengths
    frame(6'd16);
    frame(6'd32);
    apb(`ADDR_SSB, 0, 0, 33'h00);
    frame(6'd17);
    enl(2'b11);
    apb(`ADDR_SSB, 0, 0, 33'h10);
    // Shutdown and recovery below warning
    tempShutdownLive <= 1'b1;
    tempWarnLive <= 1'b1;
    cy(6);
    ck({boostEn, chanDriveEn, chanFaultOut}, 5'h00);
    apb(`ADDR_LIVE, 0, 0, 33'h40);
    tempShutdownLive <= 1'b0;
    cy(6);
    ck(boostEn, 1'b0);
    tempWarnLive <= 1'b0;
    cy(6);
    ck({boostEn, chanDriveEn, chanFaultOut}, 5'h1f);
    apb(`ADDR_SSB, 0, 0, 33'h20);
    apb(`ADDR_SSB, 0, 0, 33'h00);
    // Pulsed mode after a second reset
    rst_n <= 1'b0;
    cy(2);
    nvmDiagMode <= 1'b1;
    cy(2);
    rst_n <= 1'b1;
    cy(12);
    ck(chanFaultOut, 2'b11);
    cy(40);
    ck(chanFaultOut, 2'b00);
    apb(`ADDR_CFG, 0, 0, 33'h80);
    end_of_test;
  end
endmodule // tb_top
